// *** common/stind_pkg.sv ***
// package of constants and types for the status indicator and service pin block
package stind_pkg;

  // clock rate and timing figures
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned CFG_TOGGLE_MS   = 1000;
  localparam int unsigned CMD_TOGGLE_MS   = 500;
  localparam int unsigned FAULT_TOGGLE_MS = 250;
  localparam int unsigned FAULT_REBOOT_MS = 5000;
  localparam int unsigned WAKE_MIN_US     = 10;
  localparam int unsigned CFG_TOGGLE_CYC   = CLK_HZ / 1000 * CFG_TOGGLE_MS;
  localparam int unsigned CMD_TOGGLE_CYC   = CLK_HZ / 1000 * CMD_TOGGLE_MS;
  localparam int unsigned FAULT_TOGGLE_CYC = CLK_HZ / 1000 * FAULT_TOGGLE_MS;
  localparam int unsigned FAULT_REBOOT_CYC = CLK_HZ / 1000 * FAULT_REBOOT_MS;
  localparam int unsigned WAKE_MIN_CYC     = (CLK_HZ / 1000000) * WAKE_MIN_US;

  // forced service serial format
  localparam logic [16:0] SERVICE_BAUD      = 17'h09600;
  localparam logic [3:0]  SERVICE_DATA_BITS = 4'h8;
  localparam logic [1:0]  SERVICE_PARITY    = 2'h0;
  localparam logic [1:0]  SERVICE_STOP_BITS = 2'h1;

  // register offsets of the plain register port
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h1;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [3:0] OFS_IRQ_EN   = 4'h3;
  localparam logic [3:0] OFS_IRQ_CLR  = 4'h4;
  localparam logic [3:0] OFS_TX_IVL   = 4'h5;
  localparam logic [3:0] OFS_FAULT    = 4'h6;
  localparam logic [3:0] OFS_SER_CFG  = 4'h7;
  localparam logic [3:0] OFS_SER_ACT  = 4'h8;

  // control register field positions
  localparam int unsigned CTRL_SEARCH  = 0;
  localparam int unsigned CTRL_RX      = 1;
  localparam int unsigned CTRL_SLEEP   = 2;
  localparam int unsigned CTRL_TX      = 3;
  localparam int unsigned CTRL_CFGCON  = 4;
  localparam int unsigned CTRL_CMDCFG  = 5;
  localparam int unsigned CTRL_ESC     = 6;
  localparam int unsigned CTRL_FAULT   = 7;
  localparam logic [7:0]  CTRL_RST     = 8'h01;
  localparam logic [23:0] TX_IVL_RST   = 24'h3D0900;
  localparam logic [7:0]  FAULT_RST    = 8'h00;

  // interrupt bit positions
  localparam int unsigned IRQ_FAULT   = 0;
  localparam int unsigned IRQ_REBOOT  = 1;
  localparam int unsigned IRQ_WAKE    = 2;
  localparam int unsigned IRQ_SVC_ON  = 3;
  localparam int unsigned IRQ_SVC_OFF = 4;
  localparam int unsigned IRQ_N       = 5;

  // serial port format
  typedef struct packed {
    logic [16:0] baud;
    logic [3:0]  data_bits;
    logic [1:0]  parity;
    logic [1:0]  stop_bits;
  } stind_ser_fmt_t;

  localparam stind_ser_fmt_t SER_CFG_RST = '{baud: 17'h1C200, data_bits: 4'h8, parity: 2'h0, stop_bits: 2'h1};

  // indicator display modes
  typedef enum logic [2:0] {
    STIND_SEARCH = 3'b000,
    STIND_RX     = 3'b001,
    STIND_SLEEP  = 3'b010,
    STIND_TX     = 3'b011,
    STIND_CFGCON = 3'b100,
    STIND_CMD    = 3'b101,
    STIND_FAULT  = 3'b110
  } stind_mode_t;

endpackage : stind_pkg

// *** src/stind_blinker.sv ***
// toggling generator for the status indicator
`timescale 1ns/100ps
module stind_blinker
  import stind_pkg::*;
#(
  parameter int unsigned CW = 32
) (
  input  wire logic          clk,       // module clock
  input  wire logic          rst,       // sync reset
  input  wire logic          restart,   // pulse: restart the interval
  input  wire logic [CW-1:0] interval,  // cycles between level changes
  output logic               level      // toggling level
);

  logic [CW-1:0] cnt_ff;
  logic          lvl_ff;
  wire           wrap = (cnt_ff + 1'b1 >= interval);

  // one level change per full interval, interval 0 treated as 1
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_ff <= '0;
      lvl_ff <= 1'b1;
    end else if (wrap) begin
      cnt_ff <= '0;
      lvl_ff <= ~lvl_ff;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign level = lvl_ff;

endmodule : stind_blinker

// *** src/stind_top.sv ***
// status indicator, service pin and fault supervision of the radio module
//
// What this block does
// - searching for a frame: indicator held at one
// - indicator low during each received frame, high afterwards
// - light sleep: indicator held at zero
// - transmitting: indicator toggles at the transmission interval
// - configuration tool connected: indicator toggles every 1 s
// - command mode off but escape-enabled: toggle every 500 ms
// - fault: toggle every 250 ms, fault code stays readable
// - maintenance input low forces serial port to 38400 8N1
// - maintenance input changes no stored setting and no mode
// - maintenance input low forces the settings command set on
// - maintenance input active low with internal pull-up
// - serial data input active low, pulled up, idles high
// - clear-to-send driven active low when data can be accepted
// - power enable high turns module on, low shuts it down
// - fault blocks radio traffic and reboots after 5 s
// - light sleep wakes on serial input change lasting 10 us
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module stind_top
  import stind_pkg::*;
#(
  parameter int unsigned REBOOT_CYC = FAULT_REBOOT_CYC,
  parameter int unsigned CFG_CYC    = CFG_TOGGLE_CYC,
  parameter int unsigned CMD_CYC    = CMD_TOGGLE_CYC,
  parameter int unsigned FLT_CYC    = FAULT_TOGGLE_CYC
) (
  input  wire logic        clk,                       // module clock, 40 MHz
  input  wire logic        rst,                       // power enable low, sync
  input  wire logic        maint_access_n,            // maintenance pin, pulled up
  input  wire logic        host_to_module_serial_in,  // serial data from host, pulled up
  input  wire logic        modem_ready,               // modem can take serial data
  input  wire logic [3:0]  reg_addr,                  // register address
  input  wire logic [31:0] reg_wdata,                 // register write data
  input  wire logic        reg_wr,                    // write strobe
  input  wire logic        reg_rd,                    // read strobe
  output logic [31:0]      reg_rdata,                 // read data, cycle after strobe
  output logic             status_ind_out,            // status indicator pin
  output logic             clear_to_send_out_n,       // clear to send, active low
  output logic             svc_active,                // service access in force
  output logic             settings_cmd_en,           // settings command set enabled
  output stind_ser_fmt_t   ser_fmt,                   // active serial format
  output logic             radio_block,               // radio traffic blocked
  output logic             reboot_req,                // pulse: reboot request
  output logic             wake_evt,                  // pulse: wake from light sleep
  output logic             irq                        // level interrupt
);

  // pin synchronisers, the first stage is read by the second only
  logic svc_s1_ff, svc_s2_ff, svc_d_ff;
  logic ser_s1_ff, ser_s2_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      svc_s1_ff <= 1'b1;
      svc_s2_ff <= 1'b1;
      svc_d_ff  <= 1'b1;
      ser_s1_ff <= 1'b1;
      ser_s2_ff <= 1'b1;
    end else begin
      svc_s1_ff <= maint_access_n;
      svc_s2_ff <= svc_s1_ff;
      svc_d_ff  <= svc_s2_ff;
      ser_s1_ff <= host_to_module_serial_in;
      ser_s2_ff <= ser_s1_ff;
    end
  end

  // service access is low-active; a floating pin idles high by pull-up
  wire svc_on   = ~svc_s2_ff;
  wire svc_rise = ~svc_s2_ff & svc_d_ff;
  wire svc_fall = svc_s2_ff & ~svc_d_ff;

  // registers written by software
  logic [7:0]     ctrl_ff;
  logic [23:0]    tx_ivl_ff;
  logic [7:0]     fault_code_ff;
  stind_ser_fmt_t ser_cfg_ff;
  logic [IRQ_N-1:0] irq_stat_ff, irq_en_ff;

  wire wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  wire wr_irq_en = reg_wr && (reg_addr == OFS_IRQ_EN);
  wire wr_irq_cl = reg_wr && (reg_addr == OFS_IRQ_CLR);
  wire wr_tx_ivl = reg_wr && (reg_addr == OFS_TX_IVL);
  wire wr_fault  = reg_wr && (reg_addr == OFS_FAULT);
  wire wr_ser    = reg_wr && (reg_addr == OFS_SER_CFG);

  // stored serial settings are never touched by the service pin
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff       <= CTRL_RST;
      tx_ivl_ff     <= TX_IVL_RST;
      fault_code_ff <= FAULT_RST;
      ser_cfg_ff    <= SER_CFG_RST;
      irq_en_ff     <= '0;
    end else begin
      if (wr_ctrl)   ctrl_ff       <= reg_wdata[7:0];
      if (wr_tx_ivl) tx_ivl_ff     <= reg_wdata[23:0];
      if (wr_fault)  fault_code_ff <= reg_wdata[7:0];
      if (wr_ser)    ser_cfg_ff    <= stind_ser_fmt_t'(reg_wdata[24:0]);
      if (wr_irq_en) irq_en_ff     <= reg_wdata[IRQ_N-1:0];
    end
  end

  // fault supervision: stays in fault until the reboot
  logic        fault_ff;
  logic [31:0] reboot_cnt_ff;
  wire         fault_set = wr_ctrl && reg_wdata[CTRL_FAULT] && !fault_ff;
  wire         reboot_now = fault_ff && (reboot_cnt_ff == REBOOT_CYC - 1);

  always_ff @(posedge clk) begin
    if (rst || reboot_now) begin
      fault_ff      <= 1'b0;
      reboot_cnt_ff <= '0;
    end else if (fault_set) begin
      fault_ff      <= 1'b1;
      reboot_cnt_ff <= '0;
    end else if (fault_ff) begin
      reboot_cnt_ff <= reboot_cnt_ff + 1'b1;
    end
  end

  assign radio_block = fault_ff;

  always_ff @(posedge clk) begin
    if (rst) reboot_req <= 1'b0;
    else     reboot_req <= reboot_now;
  end

  // wake detector: serial input must hold a changed level for 10 us
  logic [15:0] wake_cnt_ff;
  logic        wake_ff;
  wire         sleeping  = ctrl_ff[CTRL_SLEEP];
  wire         ser_moved = (ser_s2_ff != 1'b1);
  wire         wake_hit  = sleeping && ser_moved && (wake_cnt_ff == 16'(WAKE_MIN_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst || !sleeping || !ser_moved) wake_cnt_ff <= '0;
    else if (!wake_hit)                 wake_cnt_ff <= wake_cnt_ff + 16'h0001;
    else                                wake_cnt_ff <= '0;
  end

  always_ff @(posedge clk) begin
    if (rst) wake_ff <= 1'b0;
    else     wake_ff <= wake_hit;
  end
  assign wake_evt = wake_ff;

  // service access forces format and command set while held low
  assign svc_active      = svc_on;
  assign settings_cmd_en = svc_on | ctrl_ff[CTRL_CMDCFG] | ctrl_ff[CTRL_ESC];
  always_ff @(posedge clk) begin
    if (rst) ser_fmt <= SER_CFG_RST;
    else if (svc_on)
      ser_fmt <= '{baud: SERVICE_BAUD, data_bits: SERVICE_DATA_BITS,
                   parity: SERVICE_PARITY, stop_bits: SERVICE_STOP_BITS};
    else ser_fmt <= ser_cfg_ff;
  end

  // clear to send low while the modem takes data and the module is awake; a fault does not gate it
  always_ff @(posedge clk) begin
    if (rst) clear_to_send_out_n <= 1'b1;
    else     clear_to_send_out_n <= ~(modem_ready && !sleeping);
  end

  // indicator mode selection by priority
  stind_mode_t mode;
  wire cmd_blink = !ctrl_ff[CTRL_CMDCFG] && ctrl_ff[CTRL_ESC];
  assign mode = fault_ff              ? STIND_FAULT  :
                ctrl_ff[CTRL_CFGCON]  ? STIND_CFGCON :
                cmd_blink             ? STIND_CMD    :
                ctrl_ff[CTRL_TX]      ? STIND_TX     :
                ctrl_ff[CTRL_RX]      ? STIND_RX     :
                ctrl_ff[CTRL_SLEEP]   ? STIND_SLEEP  : STIND_SEARCH;

  logic [31:0] interval;
  always_comb begin
    case (mode)
      STIND_FAULT:  interval = FLT_CYC;
      STIND_CFGCON: interval = CFG_CYC;
      STIND_CMD:    interval = CMD_CYC;
      STIND_TX:     interval = {8'h00, tx_ivl_ff};
      default:      interval = 32'h00000001;
    endcase
  end

  // restart the blink phase whenever the mode changes
  stind_mode_t mode_d_ff;
  always_ff @(posedge clk) begin
    if (rst) mode_d_ff <= STIND_SEARCH;
    else     mode_d_ff <= mode;
  end

  logic blink;
  stind_blinker #(.CW(32)) u_blink (
    .clk      (clk),
    .rst      (rst),
    .restart  (mode != mode_d_ff),
    .interval (interval),
    .level    (blink)
  );

  // indicator output register
  always_ff @(posedge clk) begin
    if (rst) status_ind_out <= 1'b1;
    else begin
      case (mode)
        STIND_SEARCH: status_ind_out <= 1'b1;
        STIND_RX:     status_ind_out <= 1'b0;
        STIND_SLEEP:  status_ind_out <= 1'b0;
        STIND_TX,
        STIND_CFGCON,
        STIND_CMD,
        STIND_FAULT:  status_ind_out <= blink;
        default:      status_ind_out <= 1'b1;
      endcase
    end
  end

  // sticky interrupt status, set wins over clear
  wire [IRQ_N-1:0] irq_evt;
  assign irq_evt[IRQ_FAULT]   = fault_set;
  assign irq_evt[IRQ_REBOOT]  = reboot_now;
  assign irq_evt[IRQ_WAKE]    = wake_hit;
  assign irq_evt[IRQ_SVC_ON]  = svc_rise;
  assign irq_evt[IRQ_SVC_OFF] = svc_fall;
  wire [IRQ_N-1:0] irq_clr = wr_irq_cl ? reg_wdata[IRQ_N-1:0] : '0;

  always_ff @(posedge clk) begin
    if (rst) irq_stat_ff <= '0;
    else     irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  // read mux; unmapped and write-only offsets read zero
  wire [31:0] status_word = {20'h00000, fault_code_ff, svc_on, settings_cmd_en, fault_ff, status_ind_out};
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      OFS_CTRL:     rd_mux = {24'h000000, ctrl_ff};
      OFS_STATUS:   rd_mux = status_word;
      OFS_IRQ_STAT: rd_mux = {27'h0000000, irq_stat_ff};
      OFS_IRQ_EN:   rd_mux = {27'h0000000, irq_en_ff};
      OFS_TX_IVL:   rd_mux = {8'h00, tx_ivl_ff};
      OFS_FAULT:    rd_mux = {24'h000000, fault_code_ff};
      OFS_SER_CFG:  rd_mux = {7'h00, ser_cfg_ff};
      OFS_SER_ACT:  rd_mux = {7'h00, ser_fmt};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst)         reg_rdata <= 32'h00000000;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= 32'h00000000;
  end

  // assertions
  property p_search_high;
    @(posedge clk) disable iff (rst) (mode == STIND_SEARCH && $past(mode) == STIND_SEARCH) |=> status_ind_out;
  endproperty
  a_search_high: assert property (p_search_high) else $error("indicator not high while searching");

  property p_rx_low;
    @(posedge clk) disable iff (rst) (mode == STIND_RX) |=> !status_ind_out;
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("indicator not low during frame");

  property p_sleep_low;
    @(posedge clk) disable iff (rst) (mode == STIND_SLEEP) |=> !status_ind_out;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("indicator not low in sleep");

  property p_fault_prio;
    @(posedge clk) disable iff (rst) fault_ff |-> (mode == STIND_FAULT && interval == FLT_CYC);
  endproperty
  a_fault_prio: assert property (p_fault_prio) else $error("fault does not own indicator");

  property p_svc_fmt;
    @(posedge clk) disable iff (rst) svc_on |=> (ser_fmt.baud == SERVICE_BAUD && ser_fmt.parity == SERVICE_PARITY);
  endproperty
  a_svc_fmt: assert property (p_svc_fmt) else $error("service format not forced");

  property p_svc_cmd;
    @(posedge clk) disable iff (rst) svc_on |-> settings_cmd_en;
  endproperty
  a_svc_cmd: assert property (p_svc_cmd) else $error("command set not forced on");

  property p_restore;
    @(posedge clk) disable iff (rst) (!svc_on && $past(svc_on) && !wr_ser) |=> (ser_fmt == ser_cfg_ff);
  endproperty
  a_restore: assert property (p_restore) else $error("serial settings not restored");

  property p_cfg_keep;
    @(posedge clk) disable iff (rst) ((svc_rise || svc_fall) && !wr_ser && !wr_ctrl) |=>
      ($stable(ser_cfg_ff) && $stable(ctrl_ff));
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("stored settings changed");

  property p_cts;
    @(posedge clk) disable iff (rst) (modem_ready && !sleeping) |=> !clear_to_send_out_n;
  endproperty
  a_cts: assert property (p_cts) else $error("clear to send not asserted");

  property p_reboot;
    @(posedge clk) disable iff (rst) reboot_now |=> (reboot_req && !fault_ff);
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot not issued");

  property p_cts_off;
    @(posedge clk) disable iff (rst) (!modem_ready || sleeping) |=> clear_to_send_out_n;
  endproperty
  a_cts_off: assert property (p_cts_off) else $error("clear to send asserted while not ready");

  property p_fault_block;
    @(posedge clk) disable iff (rst) fault_set |=> (radio_block && irq_stat_ff[IRQ_FAULT]);
  endproperty
  a_fault_block: assert property (p_fault_block) else $error("fault does not block radio traffic");

  property p_cmd_cfg_on;
    @(posedge clk) disable iff (rst) (ctrl_ff[CTRL_CMDCFG] && !fault_ff && !ctrl_ff[CTRL_CFGCON]) |-> (mode != STIND_CMD);
  endproperty
  a_cmd_cfg_on: assert property (p_cmd_cfg_on) else $error("command blink while command mode on");

  // spacing between indicator changes, counted once the blink phase has settled
  logic [31:0] ind_run_ff;
  logic        ind_prev_ff;
  logic [1:0]  ind_seen_ff;
  wire         ind_edge = (status_ind_out != ind_prev_ff);

  // the first changes after a mode switch may be restart artefacts, so they are not judged
  always_ff @(posedge clk) begin
    if (rst) begin
      ind_run_ff  <= 32'h00000000;
      ind_prev_ff <= 1'b1;
      ind_seen_ff <= 2'h0;
    end else begin
      ind_prev_ff <= status_ind_out;
      ind_run_ff  <= ind_edge ? 32'h00000001 : ind_run_ff + 32'h00000001;
      if (mode != mode_d_ff)                    ind_seen_ff <= 2'h0;
      else if (ind_edge && ind_seen_ff != 2'h3) ind_seen_ff <= ind_seen_ff + 2'h1;
    end
  end

  property p_blink_ivl;
    @(posedge clk) disable iff (rst) (ind_edge && ind_seen_ff == 2'h3 && mode == mode_d_ff &&
      (mode == STIND_FAULT || mode == STIND_CFGCON || mode == STIND_CMD)) |-> (ind_run_ff == interval);
  endproperty
  a_blink_ivl: assert property (p_blink_ivl) else $error("indicator blink spacing wrong");

endmodule : stind_top

// *** tb/stind_host_model.sv ***
// host terminal model driving the service and serial data pins
`timescale 1ns/100ps
module stind_host_model (
  input  wire logic clk,      // module clock
  output logic      maint_n,  // service pin level
  output logic      ser_in    // serial data toward module
);
  // undriven pins rest at their pull-up level
  initial begin
    maint_n = 1'h1;
    ser_in  = 1'h1;
  end

  // pull the service pin low, or hand it back to the pull-up
  task svc(input logic on);
    @(posedge clk);
    maint_n <= ~on;
  endtask : svc

  // hold the idle line low for n cycles, a wake request from sleep
  task brk(input int n);
    @(posedge clk);
    ser_in <= 1'h0;
    repeat (n) @(posedge clk);
    ser_in <= 1'h1;
  endtask : brk
endmodule : stind_host_model

// *** tb/tb_top.sv ***
// self-checking bench for the status indicator and service pin block
`timescale 1ns/100ps
module tb_top;
  import stind_pkg::*;
  typedef struct packed {
    logic [7:0]  c;  // control value
    logic        m;  // modem ready level
    logic [31:0] v;  // indicator level or blink interval
    logic        k;  // clear to send level
  } stind_row_t;

  logic           clk, rst, modem_ready, reg_wr, reg_rd, maint_n, ser_in;
  logic [3:0]     reg_addr;
  logic [31:0]    reg_wdata, reg_rdata, rdv;
  logic           status_ind_out, clear_to_send_out_n, svc_active, settings_cmd_en;
  logic           radio_block, reboot_req, wake_evt, irq;
  stind_ser_fmt_t ser_fmt;
  wire logic [3:0] ev;
  int             n_errors, compares, n;
  // static levels per control value, then toggle intervals in cycles
  stind_row_t st_rows[6] = '{'{8'h01, 1'h1, 32'h1, 1'h0}, '{8'h03, 1'h0, 32'h0, 1'h1},
                             '{8'h01, 1'h1, 32'h1, 1'h0}, '{8'h04, 1'h1, 32'h0, 1'h1},
                             '{8'h06, 1'h0, 32'h0, 1'h1}, '{8'h61, 1'h1, 32'h1, 1'h0}};
  stind_row_t tg_rows[6] = '{'{8'h10, 1'h1, 32'h28, 1'h0}, '{8'h40, 1'h1, 32'h14, 1'h0},
                             '{8'h08, 1'h1, 32'h1E, 1'h0}, '{8'h18, 1'h1, 32'h28, 1'h0},
                             '{8'h50, 1'h1, 32'h28, 1'h0}, '{8'h48, 1'h1, 32'h14, 1'h0}};

  assign ev = {irq, wake_evt, reboot_req, svc_active};

  // short counts keep the blink and reboot waits brief
  stind_top #(.REBOOT_CYC(100), .CFG_CYC(40), .CMD_CYC(20), .FLT_CYC(10)) u_dut (
    .clk(clk), .rst(rst), .maint_access_n(maint_n), .host_to_module_serial_in(ser_in),
    .modem_ready(modem_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_ind_out(status_ind_out),
    .clear_to_send_out_n(clear_to_send_out_n), .svc_active(svc_active),
    .settings_cmd_en(settings_cmd_en), .ser_fmt(ser_fmt), .radio_block(radio_block),
    .reboot_req(reboot_req), .wake_evt(wake_evt), .irq(irq));

  stind_host_model u_host (.clk(clk), .maint_n(maint_n), .ser_in(ser_in));

  // 40 MHz clock
  initial clk = 1'h0;
  always #12.5 clk = ~clk;

  task end_of_test;
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd   <= 1'h0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // watch one event line for lim cycles; a missed event ends the run
  task wait_ev(input int i, input int lim, input logic exp);
    logic f;
    f = 1'h0;
    repeat (lim) begin
      @(negedge clk);
      if (ev[i] === 1'h1) f = 1'h1;
    end
    chk(f, exp);
    if (exp && !f) end_of_test;
  endtask : wait_ev

  // cycles between two successive indicator changes
  task meas(output int c);
    logic p;
    int   k;
    c = 0;
    k = 0;
    @(negedge clk);
    p = status_ind_out;
    while (status_ind_out === p && k < 400) begin
      @(negedge clk);
      k++;
    end
    p = status_ind_out;
    while (status_ind_out === p && c < 400) begin
      @(negedge clk);
      c++;
    end
    if (c >= 400) begin
      n_errors++;
      end_of_test;
    end
  endtask : meas

  initial begin
    n_errors = 0;
    compares = 0;
    rst = 1'h1;
    modem_ready = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    modem_ready <= 1'h1;
    @(negedge clk);
    chk(status_ind_out, 1'h1);
    chk({7'h00, ser_fmt}, {7'h00, SER_CFG_RST});
    // ordinary cases: static levels and clear to send, then blink intervals
    foreach (st_rows[i]) begin
      @(posedge clk);
      modem_ready <= st_rows[i].m;
      wr(OFS_CTRL, {24'h0, st_rows[i].c});
      repeat (4) @(negedge clk);
      chk(status_ind_out, st_rows[i].v);
      chk(clear_to_send_out_n, st_rows[i].k);
    end
    chk(clear_to_send_out_n, 1'h0);
    wr(OFS_TX_IVL, 32'h1E);
    foreach (tg_rows[i]) begin
      wr(OFS_CTRL, {24'h0, tg_rows[i].c});
      repeat (3) @(negedge clk);
      meas(n);
      chk(n, tg_rows[i].v);
    end
    // service access forces the format but keeps stored settings
    wr(OFS_CTRL, 32'h01);
    u_host.svc(1'h1);
    wait_ev(0, 8, 1'h1);
    chk({7'h00, ser_fmt}, {7'h00, 17'h09600, 4'h8, 2'h0, 2'h1});
    chk(settings_cmd_en, 1'h1);
    rd(OFS_SER_ACT, rdv);
    chk(rdv, {7'h00, 17'h09600, 4'h8, 2'h0, 2'h1});
    rd(OFS_CTRL, rdv);
    chk(rdv, 32'h01);
    rd(OFS_SER_CFG, rdv);
    chk(rdv, {7'h00, SER_CFG_RST});
    u_host.svc(1'h0);
    repeat (6) @(negedge clk);
    chk({7'h00, ser_fmt}, {7'h00, SER_CFG_RST});
    chk(settings_cmd_en, 1'h0);
    rd(OFS_IRQ_STAT, rdv);
    chk(rdv, 32'h18);
    // sleep: a short break must not wake, a long one must
    wr(OFS_IRQ_EN, 32'h04);
    wr(OFS_CTRL, 32'h04);
    repeat (3) @(negedge clk);
    chk(clear_to_send_out_n, 1'h1);
    fork u_host.brk(100); wait_ev(2, 120, 1'h0); join
    fork u_host.brk(450); wait_ev(2, 460, 1'h1); join
    chk(irq, 1'h1);
    wr(OFS_IRQ_CLR, 32'h04);
    repeat (2) @(negedge clk);
    chk(irq, 1'h0);
    // fault with its interrupt masked, then unmasked
    wr(OFS_IRQ_EN, 32'h00);
    wr(OFS_FAULT, 32'h5A);
    wr(OFS_CTRL, 32'h81);
    repeat (3) @(negedge clk);
    chk(radio_block, 1'h1);
    chk(irq, 1'h0);
    meas(n);
    chk(n, 32'h0A);
    rd(OFS_STATUS, rdv);
    chk(rdv[11:1], 32'h2D1);
    wr(OFS_IRQ_EN, 32'h01);
    repeat (2) @(negedge clk);
    chk(irq, 1'h1);
    wait_ev(1, 120, 1'h1);
    chk(radio_block, 1'h0);
    // unmapped and write-only places read zero
    rd(4'hF, rdv);
    chk(rdv, 32'h0);
    rd(OFS_IRQ_CLR, rdv);
    chk(rdv, 32'h0);
    // second reset in mid-run
    wr(OFS_CTRL, 32'h10);
    @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(negedge clk);
    chk(status_ind_out, 1'h1);
    chk(clear_to_send_out_n, 1'h1);
    chk(irq, 1'h0);
    @(posedge clk);
    rst <= 1'h0;
    rd(OFS_CTRL, rdv);
    chk(rdv, 32'h01);
    end_of_test;
  end
endmodule : tb_top
